// File: logic/uart_pkg.sv
// Purpose: shared constants and types for the serial port core
// Assumes: apb, 32-bit data, one word per register
// Notes: offsets are byte addresses
package uart_pkg;
  localparam logic [11:0] data_off = 12'h000;
  localparam logic [11:0] status_off = 12'h004;
  localparam logic [11:0] int_div_off = 12'h024;
  localparam logic [11:0] frac_div_off = 12'h028;
  localparam logic [11:0] line_ctrl_off = 12'h02c;
  localparam logic [11:0] port_ctrl_off = 12'h030;
  localparam logic [11:0] level_sel_off = 12'h034;
  localparam logic [11:0] lp_div_off = 12'h038;
  // line control field positions
  localparam int lc_break_pos = 0;
  localparam int lc_par_en_pos = 1;
  localparam int lc_even_pos = 2;
  localparam int lc_two_stop_pos = 3;
  localparam int lc_fifo_en_pos = 4;
  localparam int lc_len_lsb = 5;
  localparam int lc_stick_pos = 7;
  // port control field positions
  localparam int pc_enable_pos = 0;
  localparam int pc_ir_pos = 1;
  localparam int pc_lowpower_pos = 2;
  localparam int pc_tx_pos = 8;
  localparam int pc_rx_pos = 9;
  localparam logic [9:0] port_ctrl_rst = 10'h300;
  localparam logic [5:0] level_sel_rst = 6'h12;
  localparam logic [15:0] int_div_rst = 16'h0000;
  localparam logic [7:0] lp_div_rst = 8'h00;
  localparam int fifo_depth = 16;
  localparam int ptr_w = 4;
  localparam logic [3:0] ticks_per_bit = 4'hf;
  localparam logic [3:0] start_check_tick = 4'h7;
  localparam logic [3:0] ir_pulse_ticks = 4'h3;
  localparam logic [1:0] lp_pulse_cycles = 2'h3;

  typedef struct packed {
    logic [15:0] div_int;
    logic [5:0] div_frac;
    logic [7:0] line;
  } frame_cfg_t;

  typedef struct packed {
    logic brk;
    logic par_err;
    logic frm_err;
    logic [7:0] data;
  } rx_word_t;

  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_start = 3'b001,
    st_data = 3'b011,
    st_parity = 3'b010,
    st_stop = 3'b110
  } ser_state_t;

  // trigger level in entries for a 3-bit level select
  function automatic logic [4:0] level_of(input logic [2:0] sel);
    case (sel)
      3'h0: level_of = 5'h02;
      3'h1: level_of = 5'h04;
      3'h2: level_of = 5'h08;
      3'h3: level_of = 5'h0c;
      default: level_of = 5'h0e;
    endcase
  endfunction
endpackage

// File: logic/uart_core.sv
// Purpose: async serial transmitter/receiver with fifos, apb registers
// Assumes: pclk 20 MHz, serial_in_pin from outside the clock domain
// Notes: interrupt logic lives elsewhere; levels are status outputs
`timescale 1ns/1ns
module uart_core
  import uart_pkg::*;
(
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic serial_in_pin, // serial or ir receive pin
  output logic serial_out_pin, // serial or ir transmit pin
  output logic tx_level_hit, // tx fifo at or below trigger
  output logic rx_level_hit // rx fifo at or above trigger
);
  logic [15:0] divisor_integer_reg;
  logic [5:0] divisor_fraction_reg;
  logic [7:0] line_control_high_reg;
  frame_cfg_t cfg_reg;
  logic [9:0] port_control_reg;
  logic [5:0] level_reg;
  logic [7:0] lp_div_reg;
  logic port_global_enable, tx_dir_enable, rx_dir_enable, fifo_enable_bit;
  logic ir_mode, lowpower;
  logic wr_acc, rd_acc, addr_ok;
  assign port_global_enable = port_control_reg[pc_enable_pos];
  assign ir_mode = port_control_reg[pc_ir_pos];
  assign lowpower = port_control_reg[pc_lowpower_pos];
  assign tx_dir_enable = port_control_reg[pc_tx_pos];
  assign rx_dir_enable = port_control_reg[pc_rx_pos];
  assign fifo_enable_bit = cfg_reg.line[lc_fifo_en_pos];
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign pready = 1'b1;
  always_comb
  begin
    case (paddr)
      data_off, status_off, int_div_off, frac_div_off, line_ctrl_off,
      port_ctrl_off, level_sel_off, lp_div_off: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !addr_ok;

  // control registers; divisors only take effect with a line write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      divisor_integer_reg <= int_div_rst;
      divisor_fraction_reg <= 6'h00;
      line_control_high_reg <= 8'h00;
      cfg_reg <= '0;
      port_control_reg <= port_ctrl_rst;
      level_reg <= level_sel_rst;
      lp_div_reg <= lp_div_rst;
    end
    else if (wr_acc)
    begin
      case (paddr)
        int_div_off: divisor_integer_reg <= pwdata[15:0];
        frac_div_off: divisor_fraction_reg <= pwdata[5:0];
        line_ctrl_off:
        begin
          line_control_high_reg <= pwdata[7:0];
          cfg_reg <= {divisor_integer_reg, divisor_fraction_reg,
                      pwdata[7:0]};
        end
        port_ctrl_off: port_control_reg <= pwdata[9:0];
        level_sel_off: level_reg <= pwdata[5:0];
        lp_div_off: lp_div_reg <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // fractional tick generator: count int part, stretch by fraction carry
  logic [15:0] tick_cnt;
  logic [6:0] frac_acc;
  logic oversample_tick;
  logic [6:0] frac_sum;
  assign frac_sum = {1'b0, frac_acc[5:0]} + {1'b0, cfg_reg.div_frac};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_cnt <= 16'h0000;
      frac_acc <= 7'h00;
      oversample_tick <= 1'b0;
    end
    else
    begin
      oversample_tick <= 1'b0;
      if (cfg_reg.div_int == 16'h0000)
        tick_cnt <= 16'h0000;
      else if (tick_cnt == 16'h0000)
      begin
        oversample_tick <= 1'b1;
        frac_acc <= frac_sum;
        tick_cnt <= cfg_reg.div_int - (frac_sum[6] ? 16'h0000 : 16'h0001);
      end
      else
        tick_cnt <= tick_cnt - 16'h0001;
    end
  end

  // low-power ir pulse clock, reload value + 1 divides by 1..256
  logic [7:0] lp_cnt;
  logic lp_tick;
  logic ir_start;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lp_cnt <= 8'h00;
      lp_tick <= 1'b0;
    end
    else if (ir_start)
    begin
      // restart so a pulse lasts exactly three divided periods
      lp_cnt <= (lp_div_reg == 8'h00) ? 8'h00 : lp_div_reg - 8'h01;
      lp_tick <= (lp_div_reg == 8'h00);
    end
    else if (lp_cnt == 8'h00)
    begin
      lp_cnt <= lp_div_reg;
      lp_tick <= 1'b1;
    end
    else
    begin
      lp_cnt <= lp_cnt - 8'h01;
      lp_tick <= 1'b0;
    end
  end

  // fifos: depth 16 when enabled, else one-byte holding register
  logic [7:0] tx_mem [fifo_depth];
  rx_word_t rx_mem [fifo_depth];
  logic [ptr_w:0] tx_wp, tx_rp, rx_wp, rx_rp;
  logic [4:0] tx_cnt, rx_cnt, cap;
  logic tx_full, rx_full, tx_push, tx_pop, rx_push, rx_pop;
  logic overrun_reg;
  rx_word_t rx_new;
  assign tx_cnt = tx_wp - tx_rp;
  assign rx_cnt = rx_wp - rx_rp;
  assign cap = fifo_enable_bit ? 5'h10 : 5'h01;
  assign tx_full = (tx_cnt >= cap);
  assign rx_full = (rx_cnt >= cap);
  assign tx_push = wr_acc && (paddr == data_off) && !tx_full;
  assign rx_pop = rd_acc && (paddr == data_off) && (rx_cnt != 5'h00);
  assign tx_level_hit = tx_cnt <= level_of(level_reg[2:0]);
  assign rx_level_hit = rx_cnt >= level_of(level_reg[5:3]);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_wp <= '0;
      tx_rp <= '0;
      rx_wp <= '0;
      rx_rp <= '0;
    end
    else
    begin
      if (tx_push)
        tx_wp <= tx_wp + 5'h01;
      if (tx_pop)
        tx_rp <= tx_rp + 5'h01;
      if (rx_push && !rx_full)
        rx_wp <= rx_wp + 5'h01;
      if (rx_pop)
        rx_rp <= rx_rp + 5'h01;
    end
  end

  always_ff @(posedge pclk)
  begin
    if (tx_push)
      tx_mem[tx_wp[ptr_w-1:0]] <= pwdata[7:0];
    if (rx_push && !rx_full)
      rx_mem[rx_wp[ptr_w-1:0]] <= rx_new;
  end

  // overrun stays set until read of status; a new overrun wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      overrun_reg <= 1'b0;
    else if (rx_push && rx_full)
      overrun_reg <= 1'b1;
    else if (rd_acc && paddr == status_off)
      overrun_reg <= 1'b0;
  end

  // transmitter
  ser_state_t tx_st;
  logic [3:0] tx_tick, tx_bit;
  logic [7:0] tx_sh;
  logic tx_par, tx_line, tx_stop2;
  logic [3:0] nbits;
  assign nbits = 4'h5 + {2'b00, cfg_reg.line[lc_len_lsb+1:lc_len_lsb]};
  assign tx_pop = (tx_st == st_idle) && port_global_enable && tx_dir_enable
                  && (tx_cnt != 5'h00) && oversample_tick;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_st <= st_idle;
      tx_tick <= 4'h0;
      tx_bit <= 4'h0;
      tx_sh <= 8'h00;
      tx_par <= 1'b0;
      tx_line <= 1'b1;
      tx_stop2 <= 1'b0;
    end
    else if (tx_pop)
    begin
      tx_st <= st_start;
      tx_sh <= tx_mem[tx_rp[ptr_w-1:0]];
      tx_tick <= 4'h0;
      tx_line <= 1'b0;
      tx_par <= 1'b0;
    end
    else if (oversample_tick && tx_st != st_idle)
    begin
      tx_tick <= tx_tick + 4'h1;
      if (tx_tick == ticks_per_bit)
      begin
        case (tx_st)
          st_start, st_data:
          begin
            if (tx_st == st_data && tx_bit == nbits)
            begin
              if (cfg_reg.line[lc_par_en_pos])
              begin
                tx_st <= st_parity;
                tx_line <= cfg_reg.line[lc_stick_pos]
                  ? !cfg_reg.line[lc_even_pos]
                  : tx_par ^ !cfg_reg.line[lc_even_pos];
              end
              else
              begin
                tx_st <= st_stop;
                tx_line <= 1'b1;
              end
              tx_stop2 <= cfg_reg.line[lc_two_stop_pos];
            end
            else
            begin
              if (tx_st == st_start)
                tx_bit <= 4'h1;
              else
                tx_bit <= tx_bit + 4'h1;
              tx_st <= st_data;
              tx_line <= tx_sh[0];
              tx_par <= tx_par ^ tx_sh[0];
              tx_sh <= {1'b0, tx_sh[7:1]};
            end
          end
          st_parity:
          begin
            tx_st <= st_stop;
            tx_line <= 1'b1;
          end
          st_stop:
          begin
            // finishes even if enable dropped meanwhile
            if (tx_stop2)
              tx_stop2 <= 1'b0;
            else
              tx_st <= st_idle;
          end
          default: tx_st <= st_idle;
        endcase
      end
    end
  end

  // ir encoder: pulse high for zero bits; 3/16 bit or 3 lp clocks
  logic [3:0] ir_ticks;
  logic [1:0] lp_left;
  logic tx_drv;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ir_ticks <= 4'h0;
      lp_left <= 2'h0;
      serial_out_pin <= 1'b1;
    end
    else
    begin
      if (ir_start)
      begin
        ir_ticks <= ir_pulse_ticks;
        lp_left <= lp_pulse_cycles;
      end
      else
      begin
        if (oversample_tick && ir_ticks != 4'h0)
          ir_ticks <= ir_ticks - 4'h1;
        if (lp_tick && lp_left != 2'h0)
          lp_left <= lp_left - 2'h1;
      end
      if (!ir_mode)
        serial_out_pin <= tx_drv;
      else if (lowpower)
        serial_out_pin <= !tx_drv && (lp_left != 2'h0);
      else
        serial_out_pin <= !tx_drv && (ir_ticks != 4'h0);
    end
  end
  assign tx_drv = tx_line && !cfg_reg.line[lc_break_pos];
  assign ir_start = (tx_tick == 4'h0) && oversample_tick && !tx_drv;

  // receive pin synchroniser; no ir decode follows it
  logic rx_s1, rx_s2, rx_bit;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
    end
    else
    begin
      rx_s1 <= serial_in_pin;
      rx_s2 <= rx_s1;
    end
  end
  // ir receiver already pulls low on light, so it reads like plain data
  assign rx_bit = rx_s2;

  // receiver
  ser_state_t rx_st;
  logic [3:0] rx_tick, rx_bitn;
  logic [7:0] rx_sh;
  logic rx_par, rx_perr, rx_allz;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_st <= st_idle;
      rx_tick <= 4'h0;
      rx_bitn <= 4'h0;
      rx_sh <= 8'h00;
      rx_par <= 1'b0;
      rx_perr <= 1'b0;
      rx_allz <= 1'b0;
      rx_push <= 1'b0;
      rx_new <= '0;
    end
    else
    begin
      rx_push <= 1'b0;
      if (oversample_tick)
      begin
        rx_tick <= rx_tick + 4'h1;
        case (rx_st)
          st_idle:
            if (!rx_bit && port_global_enable && rx_dir_enable)
            begin
              rx_st <= st_start;
              rx_tick <= 4'h0;
            end
          st_start:
            if (rx_tick == start_check_tick)
            begin
              if (rx_bit)
                rx_st <= st_idle;
              else
              begin
                rx_st <= st_data;
                rx_tick <= 4'h0;
                rx_bitn <= 4'h0;
                rx_par <= 1'b0;
                rx_allz <= 1'b1;
                rx_sh <= 8'h00;
              end
            end
          st_data:
            if (rx_tick == ticks_per_bit)
            begin
              rx_sh[rx_bitn[2:0]] <= rx_bit;
              rx_par <= rx_par ^ rx_bit;
              rx_allz <= rx_allz && !rx_bit;
              rx_bitn <= rx_bitn + 4'h1;
              if (rx_bitn + 4'h1 == nbits)
                rx_st <= cfg_reg.line[lc_par_en_pos] ? st_parity : st_stop;
            end
          st_parity:
            if (rx_tick == ticks_per_bit)
            begin
              rx_perr <= cfg_reg.line[lc_stick_pos]
                ? (rx_bit != !cfg_reg.line[lc_even_pos])
                : ((rx_par ^ rx_bit) != !cfg_reg.line[lc_even_pos]);
              rx_allz <= rx_allz && !rx_bit;
              rx_st <= st_stop;
            end
          st_stop:
            if (rx_tick == ticks_per_bit)
            begin
              rx_push <= 1'b1;
              rx_new.data <= rx_sh;
              rx_new.frm_err <= !rx_bit;
              rx_new.par_err <= rx_perr;
              rx_new.brk <= rx_allz && !rx_bit;
              rx_perr <= 1'b0;
              rx_st <= st_idle;
            end
          default: rx_st <= st_idle;
        endcase
      end
    end
  end

  // read data mux, registered
  rx_word_t rx_head;
  assign rx_head = rx_mem[rx_rp[ptr_w-1:0]];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        data_off: prdata <= {20'h00000, overrun_reg, rx_head};
        status_off: prdata <= {24'h000000, tx_st != st_idle, tx_full,
                               rx_full, tx_cnt == 5'h00, rx_cnt == 5'h00,
                               rx_st != st_idle, 1'b0, overrun_reg};
        int_div_off: prdata <= {16'h0000, divisor_integer_reg};
        frac_div_off: prdata <= {26'h0000000, divisor_fraction_reg};
        line_ctrl_off: prdata <= {24'h000000, line_control_high_reg};
        port_ctrl_off: prdata <= {22'h000000, port_control_reg};
        level_sel_off: prdata <= {26'h0000000, level_reg};
        lp_div_off: prdata <= {24'h000000, lp_div_reg};
        default: prdata <= 32'h00000000;
      endcase
    end
  end
endmodule // uart_core

// File: tb/uart_chk.sv
// Purpose: port-level checks for the serial port core
// Assumes: apb with zero wait states, plain line idles high
// Notes: bound to every uart_core instance
`timescale 1ns/1ns
module uart_chk
  import uart_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // select
  input wire logic penable, // enable
  input wire logic pwrite, // direction
  input wire logic [11:0] paddr, // address
  input wire logic [31:0] pwdata, // write data
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic serial_in_pin, // receive pin
  input wire logic serial_out_pin, // transmit pin
  input wire logic tx_level_hit, // tx level
  input wire logic rx_level_hit // rx level
);
  logic acc;
  logic mapped;
  assign acc = psel && penable;
  assign mapped = paddr inside {data_off, status_off, int_div_off,
    frac_div_off, line_ctrl_off, port_ctrl_off, level_sel_off, lp_div_off};
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ready_seen_a: assert property (acc |-> pready)
    else $error("access phase without ready");
  err_phase_a: assert property (pslverr |-> acc)
    else $error("error outside access phase");
  unmapped_err_a: assert property (acc && !mapped |-> pslverr)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (acc && mapped |-> !pslverr)
    else $error("mapped access refused");
  unmapped_zero_a: assert property (acc && !pwrite && !mapped
    |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!(psel && !penable && !pwrite)
    |=> $stable(prdata))
    else $error("read data moved outside read setup");
  break_drive_a: assert property (
    acc && pwrite && paddr == line_ctrl_off
    && pwdata[lc_break_pos] |-> ##[1:3] !serial_out_pin [*4])
    else $error("break not driven");
  reset_idle_a: assert property (
    $rose(presetn) |-> serial_out_pin && tx_level_hit && !rx_level_hit)
    else $error("bad idle state after reset");
  cover property (acc && !mapped);
  cover property (acc && pwrite && paddr == line_ctrl_off);
  cover property ($fell(serial_out_pin));
endmodule // uart_chk

bind uart_core uart_chk chk_i (.*);

// File: tb/serial_peer.sv
// Purpose: remote serial device on the far side of the pins
// Assumes: bit time in pclk cycles given by bit_clks
// Notes: sends frames on demand, decodes every frame it sees
`timescale 1ns/1ns
module serial_peer
(
  input wire logic pclk, // clock
  input wire logic line_in, // core transmit pin
  input wire logic [5:0] bit_clks, // clocks per bit
  input wire logic [3:0] nbits, // data bits
  input wire logic par_en, // parity bit present
  input wire logic two_stop, // second stop present
  output logic line_out, // core receive pin
  output logic got, // pulse per decoded frame
  output logic [9:0] got_word // stop ok, parity, data
);
  logic [9:0] w;
  initial
  begin
    line_out = 1'b1;
    got = 1'b0;
    got_word = 10'h0;
  end
  task automatic send(input logic [7:0] d, input logic p,
    input logic stop);
    line_out <= 1'b0;
    repeat (bit_clks) @(posedge pclk);
    for (int i = 0; i < nbits; i++)
    begin
      line_out <= d[i];
      repeat (bit_clks) @(posedge pclk);
    end
    if (par_en)
    begin
      line_out <= p;
      repeat (bit_clks) @(posedge pclk);
    end
    line_out <= stop;
    repeat (bit_clks) @(posedge pclk);
    // idle high: the line has a pull-up
    line_out <= 1'b1;
    repeat (bit_clks) @(posedge pclk);
  endtask
  task automatic glitch();
    line_out <= 1'b0;
    repeat (4) @(posedge pclk);
    line_out <= 1'b1;
    repeat (bit_clks * 12) @(posedge pclk);
  endtask
  // sample mid bit, so the design's own edge timing does not matter
  always
  begin
    @(negedge line_in);
    repeat (bit_clks / 2) @(posedge pclk);
    if (!line_in)
    begin
      w = 10'h0;
      for (int i = 0; i < nbits; i++)
      begin
        repeat (bit_clks) @(posedge pclk);
        w[i] = line_in;
      end
      if (par_en)
      begin
        repeat (bit_clks) @(posedge pclk);
        w[8] = line_in;
      end
      repeat (bit_clks) @(posedge pclk);
      w[9] = line_in;
      if (two_stop)
      begin
        repeat (bit_clks) @(posedge pclk);
        w[9] = w[9] & line_in;
      end
      got <= 1'b1;
      got_word <= w;
      @(posedge pclk);
      got <= 1'b0;
    end
  end
endmodule // serial_peer

// File: tb/async_serial_uart_core_tb_top.sv
// Purpose: self-checking bench for the serial port core
// Assumes: divisor kept at 1 or 2 so a bit lasts 16 to 32 clocks
// Notes: expectations queue up and are checked as results appear
`timescale 1ns/1ns
module async_serial_uart_core_tb_top
  import uart_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, serial_in_pin, serial_out_pin;
  logic tx_level_hit, rx_level_hit, got;
  logic [9:0] got_word;
  logic [5:0] bit_clks = 6'd16;
  logic [3:0] nbits = 4'h8;
  logic par_en = 1'b0;
  logic two_stop = 1'b0;
  logic [7:0] lc = 8'h00;
  logic [7:0] b;
  logic [7:0] lc_tab [6] = '{8'h70, 8'h12, 8'h36, 8'h5a, 8'hf6, 8'hf2};
  logic [32:0] rd_q [$];
  logic [9:0] tx_q [$];
  int error_cnt = 0;
  int checks_done = 0;
  int hw_cnt = 0;
  int last_w = 0;

  always #25 pclk = ~pclk;

  uart_core uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
    .tx_level_hit(tx_level_hit), .rx_level_hit(rx_level_hit));
  serial_peer peer (.pclk(pclk), .line_in(serial_out_pin),
    .bit_clks(bit_clks), .nbits(nbits), .par_en(par_en),
    .two_stop(two_stop), .line_out(serial_in_pin), .got(got),
    .got_word(got_word));

  task automatic finish_test();
    if (error_cnt == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [32:0] s, input logic [32:0] e);
    checks_done++;
    if (s !== e)
    begin
      error_cnt++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  function automatic logic [7:0] msk(input logic [7:0] d);
    msk = d & 8'((9'h1 << nbits) - 9'h1);
  endfunction
  function automatic logic par(input logic [7:0] m);
    par = lc[lc_stick_pos] ? !lc[lc_even_pos] : ^m ^ !lc[lc_even_pos];
  endfunction
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic tx(input logic [7:0] d);
    tx_q.push_back({1'b1, par_en & par(msk(d)), msk(d)});
    apb(1'b1, data_off, {24'h0, d});
  endtask
  task automatic rx(input logic [7:0] d, input logic pf, input logic stop,
    input logic [3:0] err, input logic [7:0] st);
    peer.send(d, par(msk(d)) ^ pf, stop);
    rd(status_off, {25'h0, st});
    rd(data_off, {21'h0, err, msk(d)});
  endtask
  task automatic drain();
    for (int i = 0; i < 6000 && tx_q.size() > 0; i++)
      @(posedge pclk);
    chk(33'(tx_q.size()), 33'h0);
  endtask
  task automatic cfg(input logic [7:0] l, input logic [9:0] pc);
    apb(1'b1, port_ctrl_off, 32'h300);
    apb(1'b1, line_ctrl_off, {24'h0, l});
    lc = l;
    nbits = 4'(l[6:5]) + 4'h5;
    par_en = l[lc_par_en_pos];
    two_stop = l[lc_two_stop_pos];
    apb(1'b1, port_ctrl_off, {22'h0, pc});
  endtask

  always @(posedge pclk)
  begin
    if (psel && penable && pready && !pwrite && rd_q.size() > 0)
      chk({pslverr, prdata}, rd_q.pop_front());
    if (got && tx_q.size() > 0)
      chk({23'h0, got_word}, {23'h0, tx_q.pop_front()});
    if (serial_out_pin)
      hw_cnt++;
    else if (hw_cnt != 0)
    begin
      last_w = hw_cnt;
      hw_cnt = 0;
    end
  end

  initial
  begin
    repeat (80000) @(posedge pclk);
    error_cnt++;
    finish_test();
  end

  initial
  begin
    void'($urandom(42998));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(port_ctrl_off, 33'h300);
    rd(level_sel_off, 33'h12);
    rd(status_off, 33'h18);
    rd(12'h03c, {1'b1, 32'h0});
    chk({32'h0, tx_level_hit}, 33'h1);
    apb(1'b1, int_div_off, 32'h1);
    apb(1'b1, frac_div_off, 32'h0);
    foreach (lc_tab[i])
    begin
      cfg(lc_tab[i], 10'h301);
      repeat (2) tx(8'($urandom));
      drain();
      b = 8'($urandom);
      rx(b, 1'b0, 1'b1, 4'h0, 8'h10);
    end
    b = 8'($urandom) | 8'h01;
    rx(b, 1'b1, 1'b1, 4'h2, 8'h10);
    rx(b, 1'b0, 1'b0, 4'h1, 8'h10);
    // stick parity would send a one, so force it low for a true break
    rx(8'h00, 1'b1, 1'b0, 4'h7, 8'h10);
    peer.glitch();
    rd(status_off, 33'h18);
    cfg(8'h60, 10'h301);
    rx(b, 1'b0, 1'b1, 4'h0, 8'h30);
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, port_ctrl_off, 32'h300);
      apb(1'b1, int_div_off, (i == 2) ? 32'h1 : 32'h2);
      apb(1'b1, frac_div_off, (i == 2) ? 32'h20 : 32'h0);
      bit_clks = (i == 0) ? 6'd16 : (i == 1) ? 6'd32 : 6'd24;
      if (i != 0)
        cfg(8'h70, 10'h301);
      else
        apb(1'b1, port_ctrl_off, 32'h301);
      tx(8'($urandom));
      drain();
    end
    apb(1'b1, port_ctrl_off, 32'h300);
    apb(1'b1, int_div_off, 32'h1);
    apb(1'b1, frac_div_off, 32'h0);
    bit_clks = 6'd16;
    cfg(8'h70, 10'h301);
    tx(8'($urandom));
    repeat (40) @(posedge pclk);
    apb(1'b1, port_ctrl_off, 32'h300);
    drain();
    // tx direction off so the fifo only fills
    cfg(8'h70, 10'h201);
    repeat (15) tx(8'($urandom));
    rd(status_off, 33'h08);
    chk({32'h0, tx_level_hit}, 33'h0);
    tx(8'($urandom));
    rd(status_off, 33'h48);
    apb(1'b1, data_off, 32'hff);
    apb(1'b1, port_ctrl_off, 32'h200);
    apb(1'b1, port_ctrl_off, 32'h301);
    drain();
    cfg(8'h71, 10'h301);
    repeat (8) @(posedge pclk);
    chk({32'h0, serial_out_pin}, 33'h0);
    apb(1'b1, port_ctrl_off, 32'h300);
    apb(1'b1, lp_div_off, 32'h1);
    for (int i = 0; i < 2; i++)
    begin
      cfg(8'h70, (i == 1) ? 10'h307 : 10'h303);
      apb(1'b1, data_off, 32'h0);
      repeat (200) @(posedge pclk);
      chk(33'(last_w), (i == 1) ? 33'd6 : 33'd3);
    end
    finish_test();
  end
endmodule // async_serial_uart_core_tb_top
